/* File: hdl/rsc_pkg.sv */
// Constants shared by the reset source control block
`default_nettype none
package rsc_pkg;
    // ************************************************
    // Register map (byte addresses)
    // ************************************************
    localparam logic [3:0] PIN_SEL_OFFS     = 4'h0;
    localparam logic [3:0] FLAGS_OFFS       = 4'h4;
    localparam logic [3:0] WDT_CTRL_OFFS    = 4'h8;
    localparam logic [3:0] STATUS_OFFS      = 4'hC;
    localparam int         ADDR_W           = 4;

    // ************************************************
    // Codes and reset values
    // ************************************************
    localparam logic [7:0] PIN_CODE_PORT    = 8'h55;
    localparam logic [7:0] PIN_CODE_RESET   = 8'hAA;
    localparam logic [7:0] PIN_SEL_RST      = 8'h55;
    localparam logic [7:0] WDT_CTRL_RST     = 8'h53;
    localparam logic [4:0] WDT_CODE_ENABLE  = 5'h0A;
    localparam logic [4:0] WDT_CODE_DISABLE = 5'h15;
    localparam int         WDT_CODE_LSB     = 3;

    // ************************************************
    // Flag and status register fields
    // ************************************************
    localparam int         FLG_KEEP_ON_BIT  = 7;
    localparam int         FLG_SEL_BIT      = 3;
    localparam int         FLG_LV_BIT       = 2;
    localparam int         FLG_WD_BIT       = 0;
    localparam int         ST_TO_BIT        = 0;
    localparam int         ST_PDF_BIT       = 1;
    localparam int         ST_PINRST_BIT    = 2;

    // ************************************************
    // Timing
    // ************************************************
    localparam int         CLK_MHZ          = 100;
    localparam int         DEB_TICKS        = 3;
    localparam int         DEB_CNT_W        = 2;
    localparam int         RST_HOLD_NS      = 160;
    localparam int         RST_HOLD_CYC     = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int         HOLD_CNT_W       = 8;
    localparam int         LV_CNT_W         = 20;

    // ************************************************
    // AXI responses
    // ************************************************
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    typedef enum logic [1:0] {RSC_RUN, RSC_HOLD} rsc_state_t;
endpackage
`default_nettype wire

/* File: hdl/rsc_debounce.sv */
// Reset request delay counted in low-speed oscillator ticks
`default_nettype none
module rsc_debounce (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control
    input  wire logic tick,
    input  wire logic req,
    input  wire logic cancel,
    // Result
    output logic      fire
);
    import rsc_pkg::*;

    logic                 pend_reg;
    logic [DEB_CNT_W-1:0] cnt_reg;
    logic                 last_tick;

    // Phase of the first tick is random, so full periods seen are 2 to 3
    assign last_tick = tick && (cnt_reg == DEB_CNT_W'(DEB_TICKS - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn || cancel) begin
            pend_reg <= 1'b0;
        end else if (req) begin
            pend_reg <= 1'b1;
        end else if (pend_reg && last_tick) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || cancel || !pend_reg) begin
            cnt_reg <= '0;
        end else if (tick) begin
            cnt_reg <= cnt_reg + DEB_CNT_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fire <= 1'b0;
        end else begin
            fire <= pend_reg && last_tick && !cancel;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/rsc_top.sv */
// Reset source selection, filtering and flag logic with AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
module rsc_top #(
    parameter int LV_MIN_NS = 100000
) (
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite write address and data
    input  wire logic [rsc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read
    input  wire logic [rsc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Pins and analog monitor
    input  wire logic                       low_speed_osc_clock,
    input  wire logic                       ext_reset_pin_n,
    input  wire logic                       low_voltage_det,
    // Core status (same clock)
    input  wire logic                       sleep_idle_mode,
    input  wire logic                       wdt_timeout,
    // Reset outputs
    output logic                            core_full_reset,
    output logic                            pc_sp_clear,
    output logic                            shared_pin_is_reset,
    output logic                            idle_sysclk_keep_on,
    output logic                            timeout_flag,
    output logic                            power_down_flag
);
    import rsc_pkg::*;

    localparam int LV_MIN_CYC = (LV_MIN_NS * CLK_MHZ + 999) / 1000;

    function automatic logic pin_code_ok(input logic [7:0] code);
        pin_code_ok = (code == PIN_CODE_PORT) || (code == PIN_CODE_RESET);
    endfunction

    function automatic logic wdt_code_ok(input logic [7:0] code);
        logic [4:0] we;
        we = code[WDT_CODE_LSB +: 5];
        wdt_code_ok = (we == WDT_CODE_ENABLE) || (we == WDT_CODE_DISABLE);
    endfunction

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic       osc_last_reg;
    logic       osc_tick;
    logic       pin_n_s;
    logic       lv_s;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 3'h3;
            sync2_reg <= 3'h3;
        end else begin
            sync1_reg <= {low_voltage_det, ext_reset_pin_n, low_speed_osc_clock};
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_last_reg <= 1'b1;
        end else begin
            osc_last_reg <= sync2_reg[0];
        end
    end

    assign osc_tick = sync2_reg[0] && !osc_last_reg;
    assign pin_n_s  = sync2_reg[1];
    assign lv_s     = sync2_reg[2];

    // ************************************************
    // Registers and bus handshakes
    // ************************************************
    logic [7:0] pin_sel_reg;
    logic [7:0] wdt_ctrl_reg;
    logic       keep_on_reg;
    logic       sel_flag_reg;
    logic       lv_flag_reg;
    logic       wd_flag_reg;
    logic       to_reg;
    logic       pdf_reg;
    logic       wr_go;
    logic       rd_go;
    logic [7:0] wbyte;
    logic       wr_pin;
    logic       wr_flags;
    logic       wr_wdt;
    logic       wr_ok;

    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = rd_go;
    assign wbyte         = s_axi_wdata[7:0];
    assign wr_ok         = wr_go && s_axi_wstrb[0];
    assign wr_pin        = wr_ok && (s_axi_awaddr == PIN_SEL_OFFS);
    assign wr_flags      = wr_ok && (s_axi_awaddr == FLAGS_OFFS);
    assign wr_wdt        = wr_ok && (s_axi_awaddr == WDT_CTRL_OFFS);

    // ************************************************
    // Reset sources
    // ************************************************
    logic       sel_fire;
    logic       lv_fire;
    logic       wd_fire;
    logic       ext_hit;
    logic       wdt_full;
    logic       full_req;
    logic       lv_enable;
    logic       lv_qual;
    logic [LV_CNT_W-1:0] lv_cnt_reg;

    assign shared_pin_is_reset = (pin_sel_reg == PIN_CODE_RESET);
    // Any other code, including 0x55, leaves the pin to the port mux
    assign ext_hit   = shared_pin_is_reset && !pin_n_s;
    assign wdt_full  = wdt_timeout && !sleep_idle_mode;
    assign full_req  = sel_fire || lv_fire || wd_fire || ext_hit || wdt_full;
    assign lv_enable = !sleep_idle_mode;

    // Filter counts only while low voltage stays; any gap restarts it
    always_ff @(posedge aclk) begin
        if (!aresetn || !lv_enable || !lv_s || core_full_reset) begin
            lv_cnt_reg <= '0;
        end else if (lv_cnt_reg != LV_CNT_W'(LV_MIN_CYC)) begin
            lv_cnt_reg <= lv_cnt_reg + LV_CNT_W'(1);
        end
    end

    assign lv_qual = lv_enable && lv_s && (lv_cnt_reg == LV_CNT_W'(LV_MIN_CYC - 1));

    rsc_debounce u_sel_deb (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (osc_tick),
        .req     (wr_pin && !pin_code_ok(wbyte)),
        .cancel  (core_full_reset),
        .fire    (sel_fire)
    );

    // Sleep entry drops a pending low-voltage request too
    rsc_debounce u_lv_deb (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (osc_tick),
        .req     (lv_qual),
        .cancel  (core_full_reset || !lv_enable),
        .fire    (lv_fire)
    );

    rsc_debounce u_wd_deb (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (osc_tick),
        .req     (wr_wdt && !wdt_code_ok(wbyte)),
        .cancel  (core_full_reset),
        .fire    (wd_fire)
    );

    // ************************************************
    // Full reset stretcher
    // ************************************************
    rsc_state_t             state_reg;
    logic [HOLD_CNT_W-1:0]  hold_cnt_reg;

    // Power-on holds the core in reset as well
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg    <= RSC_HOLD;
            hold_cnt_reg <= '0;
        end else begin
            case (state_reg)
                RSC_RUN: begin
                    if (full_req) begin
                        state_reg    <= RSC_HOLD;
                        hold_cnt_reg <= '0;
                    end
                end
                RSC_HOLD: begin
                    if (full_req) begin
                        hold_cnt_reg <= '0;
                    end else if (hold_cnt_reg == HOLD_CNT_W'(RST_HOLD_CYC - 1)) begin
                        state_reg <= RSC_RUN;
                    end else begin
                        hold_cnt_reg <= hold_cnt_reg + HOLD_CNT_W'(1);
                    end
                end
                default: begin
                    state_reg <= RSC_HOLD;
                end
            endcase
        end
    end

    // Core clears PC, masks interrupts, restarts watchdog, makes ports inputs
    assign core_full_reset = (state_reg == RSC_HOLD);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_sp_clear <= 1'b0;
        end else begin
            pc_sp_clear <= wdt_timeout && sleep_idle_mode;
        end
    end

    // ************************************************
    // Control registers
    // ************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn || core_full_reset) begin
            pin_sel_reg <= PIN_SEL_RST;
        end else if (wr_pin) begin
            pin_sel_reg <= wbyte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || core_full_reset) begin
            wdt_ctrl_reg <= WDT_CTRL_RST;
            keep_on_reg  <= 1'b0;
        end else begin
            if (wr_wdt) begin
                wdt_ctrl_reg <= wbyte;
            end
            if (wr_flags) begin
                keep_on_reg <= wbyte[FLG_KEEP_ON_BIT];
            end
        end
    end

    assign idle_sysclk_keep_on = keep_on_reg;

    // ************************************************
    // Sticky source flags: hardware set wins over clear
    // ************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_flag_reg <= 1'b0;
            lv_flag_reg  <= 1'b0;
            wd_flag_reg  <= 1'b0;
        end else begin
            if (sel_fire) begin
                sel_flag_reg <= 1'b1;
            end else if (wr_flags && !wbyte[FLG_SEL_BIT]) begin
                sel_flag_reg <= 1'b0;
            end
            if (lv_fire) begin
                lv_flag_reg <= 1'b1;
            end else if (wr_flags && !wbyte[FLG_LV_BIT]) begin
                lv_flag_reg <= 1'b0;
            end
            if (wd_fire) begin
                wd_flag_reg <= 1'b1;
            end else if (wr_flags && !wbyte[FLG_WD_BIT]) begin
                wd_flag_reg <= 1'b0;
            end
        end
    end

    // Low-voltage, select and control-code resets leave both untouched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            to_reg  <= 1'b0;
            pdf_reg <= 1'b0;
        end else if (wdt_timeout) begin
            to_reg <= 1'b1;
            if (sleep_idle_mode) begin
                pdf_reg <= 1'b1;
            end
        end else if (ext_hit && sleep_idle_mode) begin
            to_reg  <= 1'b0;
            pdf_reg <= 1'b1;
        end
    end

    assign timeout_flag    = to_reg;
    assign power_down_flag = pdf_reg;

    // ************************************************
    // Bus answers
    // ************************************************
    logic [7:0] flags_rd;
    logic [7:0] status_rd;

    always_comb begin
        flags_rd                  = 8'h00;
        flags_rd[FLG_KEEP_ON_BIT] = keep_on_reg;
        flags_rd[FLG_SEL_BIT]     = sel_flag_reg;
        flags_rd[FLG_LV_BIT]      = lv_flag_reg;
        flags_rd[FLG_WD_BIT]      = wd_flag_reg;
        status_rd                 = 8'h00;
        status_rd[ST_TO_BIT]      = to_reg;
        status_rd[ST_PDF_BIT]     = pdf_reg;
        status_rd[ST_PINRST_BIT]  = shared_pin_is_reset;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            if ((s_axi_awaddr == PIN_SEL_OFFS) || (s_axi_awaddr == FLAGS_OFFS)
                || (s_axi_awaddr == WDT_CTRL_OFFS) || (s_axi_awaddr == STATUS_OFFS)) begin
                s_axi_bresp <= RESP_OKAY;
            end else begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                PIN_SEL_OFFS:  s_axi_rdata <= {24'h000000, pin_sel_reg};
                FLAGS_OFFS:    s_axi_rdata <= {24'h000000, flags_rd};
                WDT_CTRL_OFFS: s_axi_rdata <= {24'h000000, wdt_ctrl_reg};
                STATUS_OFFS:   s_axi_rdata <= {24'h000000, status_rd};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: sim/rsc_top_checker.sv */
// Port assertions for the reset source control block
`default_nettype none
module rsc_top_checker (
    // Clock, reset and write address
    input wire logic                       aclk,
    input wire logic                       aresetn,
    input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic [31:0]                s_axi_wdata,
    // Pin and core status
    input wire logic                       ext_reset_pin_n,
    input wire logic                       sleep_idle_mode,
    input wire logic                       wdt_timeout,
    // Reset outputs
    input wire logic                       core_full_reset,
    input wire logic                       pc_sp_clear,
    input wire logic                       shared_pin_is_reset,
    input wire logic                       timeout_flag,
    input wire logic                       power_down_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    import rsc_pkg::*;
    logic sel_wr;
    logic bad_code;
    // Writes during a core reset are dropped, so they are no cause
    assign sel_wr   = s_axi_awvalid && s_axi_awready && s_axi_awaddr == PIN_SEL_OFFS
                      && !core_full_reset;
    assign bad_code = s_axi_wdata[7:0] != PIN_CODE_PORT && s_axi_wdata[7:0] != PIN_CODE_RESET;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ****************************************
    // Properties
    // ****************************************
    property p_port_code;
        sel_wr && s_axi_wdata[7:0] == PIN_CODE_PORT |=> ##[0:1] !shared_pin_is_reset;
    endproperty
    a_port_code: assert property (p_port_code) else $error("port code kept reset");
    property p_reset_code;
        sel_wr && s_axi_wdata[7:0] == PIN_CODE_RESET |=> ##[0:1] shared_pin_is_reset;
    endproperty
    a_reset_code: assert property (p_reset_code) else $error("reset code ignored");
    // One slow period of 8 cycles at least before the reset
    property p_bad_code;
        sel_wr && bad_code |=> (!core_full_reset) [*8] ##[1:60] core_full_reset;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("bad code reset timing");
    property p_restore;
        core_full_reset && $past(core_full_reset) |-> !shared_pin_is_reset;
    endproperty
    a_restore: assert property (p_restore) else $error("pin select not restored");
    property p_pin_rst;
        (shared_pin_is_reset && !ext_reset_pin_n) [*4] |-> ##[0:2] core_full_reset;
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("pin low gave no reset");
    property p_wdt_run;
        wdt_timeout && !sleep_idle_mode && !core_full_reset |=>
            core_full_reset && timeout_flag && power_down_flag == $past(power_down_flag);
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("running timeout wrong");
    property p_wdt_halt;
        wdt_timeout && sleep_idle_mode && !core_full_reset |=>
            pc_sp_clear && !core_full_reset && timeout_flag && power_down_flag;
    endproperty
    a_wdt_halt: assert property (p_wdt_halt) else $error("halted timeout wrong");
    property p_por;
        $rose(aresetn) |-> !timeout_flag && !power_down_flag;
    endproperty
    a_por: assert property (p_por) else $error("flags not cleared by power-on");
    c_bad: cover property (sel_wr && bad_code);
    c_warm: cover property ($rose(pc_sp_clear));
    c_pin: cover property ($rose(shared_pin_is_reset));
endmodule
bind rsc_top rsc_top_checker i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .ext_reset_pin_n(ext_reset_pin_n), .sleep_idle_mode(sleep_idle_mode),
    .wdt_timeout(wdt_timeout), .core_full_reset(core_full_reset), .pc_sp_clear(pc_sp_clear),
    .shared_pin_is_reset(shared_pin_is_reset), .timeout_flag(timeout_flag),
    .power_down_flag(power_down_flag)
);
`default_nettype wire

/* File: sim/rsc_env_model.sv */
// Slow oscillator, shared pin and supply monitor seen by the block
`default_nettype none
module rsc_env_model (
    // Core clock
    input  wire logic aclk,
    // Lines into the block
    output logic      low_speed_osc_clock,
    output logic      ext_reset_pin_n,
    output logic      low_voltage_det
);
    timeunit 1ns;
    timeprecision 1ps;
    // Oscillator runs free, out of phase with the core clock
    initial begin
        low_speed_osc_clock = 1'b0;
        ext_reset_pin_n     = 1'b1;
        low_voltage_det     = 1'b0;
        #3;
        forever #40 low_speed_osc_clock = ~low_speed_osc_clock;
    end
    // Pull-up brings the pin back high when let go
    task automatic pull_pin(input int k);
        ext_reset_pin_n <= 1'b0;
        repeat (k) @(posedge aclk);
        ext_reset_pin_n <= 1'b1;
    endtask
    task automatic supply_dip(input int k);
        low_voltage_det <= 1'b1;
        repeat (k) @(posedge aclk);
        low_voltage_det <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: sim/tb_rsc_top.sv */
// Self-checking bench for the reset source control block
`default_nettype none
module tb_rsc_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rsc_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sleep, wdt;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, core_rst, pcsp, pin_rst;
    logic        keep_on, to_f, pd_f, osc, pin_n, lv;
    int          err_count, check_count, n, c;
    rsc_top #(.LV_MIN_NS(200)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .low_speed_osc_clock(osc), .ext_reset_pin_n(pin_n), .low_voltage_det(lv),
        .sleep_idle_mode(sleep), .wdt_timeout(wdt), .core_full_reset(core_rst),
        .pc_sp_clear(pcsp), .shared_pin_is_reset(pin_rst), .idle_sysclk_keep_on(keep_on),
        .timeout_flag(to_f), .power_down_flag(pd_f)
    );
    rsc_env_model i_env (.aclk(aclk), .low_speed_osc_clock(osc), .ext_reset_pin_n(pin_n),
        .low_voltage_det(lv));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic step();
        @(posedge aclk);
        n++;
        if (n > 300) begin
            chk(32'h0, 32'h1);
            end_sim();
        end
    endtask
    // Ready rises with the request; an idle edge follows each answer
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        n = 0;
        do begin
            step();
            if (awready && wready) begin
                awvalid <= 1'b0;
                wvalid  <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e, input bit cmp = 1'b1);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do begin
            step();
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rready <= 1'b0;
        @(posedge aclk);
        if (cmp) chk(rd, e);
    endtask
    task automatic wait_rst();
        n = 0;
        do step(); while (core_rst !== 1'b1);
        c = n;
        n = 0;
        do step(); while (core_rst !== 1'b0);
    endtask
    task automatic no_rst(input int k);
        repeat (k) begin
            @(posedge aclk);
            if (core_rst !== 1'b0) chk(core_rst, 1'b0);
        end
        check_count++;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_por();
        rc(PIN_SEL_OFFS, 32'h00000055);
        rc(STATUS_OFFS, 32'h00000000);
        wr(FLAGS_OFFS, 8'h00);
        rc(FLAGS_OFFS, 32'h00000000);
        rc(4'h2, 32'h00000000);
        chk(rresp, RESP_SLVERR);
        wr(4'h2, 8'h00);
        chk(bresp, RESP_SLVERR);
        $display("power-on test done");
    endtask
    task automatic t_pin();
        wr(PIN_SEL_OFFS, PIN_CODE_RESET);
        rc(PIN_SEL_OFFS, 32'h000000AA);
        chk(pin_rst, 1'b1);
        fork i_env.pull_pin(6); wait_rst(); join
        chk(c <= 6, 1'b1);
        rc(PIN_SEL_OFFS, 32'h00000055);
        wr(PIN_SEL_OFFS, PIN_CODE_RESET);
        wr(PIN_SEL_OFFS, PIN_CODE_PORT);
        chk(pin_rst, 1'b0);
        fork i_env.pull_pin(20); no_rst(25); join
        $display("pin test done");
    endtask
    task automatic t_code();
        wr(PIN_SEL_OFFS, 8'h33);
        wait_rst();
        chk(c >= 14 && c <= 40, 1'b1);
        rc(FLAGS_OFFS, 32'h00000008);
        wr(FLAGS_OFFS, 8'hFF);
        rc(FLAGS_OFFS, 32'h00000088);
        chk(keep_on, 1'b1);
        wr(FLAGS_OFFS, 8'h00, 4'h0);
        chk(keep_on, 1'b1);
        wr(FLAGS_OFFS, 8'h00);
        rc(FLAGS_OFFS, 32'h00000000);
        $display("select code test done");
    endtask
    task automatic t_wdcode();
        wr(WDT_CTRL_OFFS, {WDT_CODE_ENABLE, 3'h3});
        no_rst(40);
        wr(WDT_CTRL_OFFS, {WDT_CODE_DISABLE, 3'h3});
        no_rst(40);
        wr(WDT_CTRL_OFFS, 8'hFB);
        wait_rst();
        chk(c >= 14 && c <= 40, 1'b1);
        rc(FLAGS_OFFS, 32'h00000001);
        rc(WDT_CTRL_OFFS, {24'h000000, WDT_CTRL_RST});
        wr(FLAGS_OFFS, 8'h00);
        $display("watchdog code test done");
    endtask
    task automatic t_wdt();
        wr(PIN_SEL_OFFS, PIN_CODE_RESET);
        sleep <= 1'b1;
        wdt   <= 1'b1;
        @(posedge aclk);
        wdt <= 1'b0;
        @(posedge aclk);
        chk({pcsp, core_rst}, 2'b10);
        sleep <= 1'b0;
        rc(STATUS_OFFS, 32'h00000007);
        wdt <= 1'b1;
        @(posedge aclk);
        wdt <= 1'b0;
        wait_rst();
        rc(STATUS_OFFS, 32'h00000003);
        $display("timeout test done");
    endtask
    task automatic t_lv();
        fork i_env.supply_dip(10); no_rst(60); join
        sleep <= 1'b1;
        fork i_env.supply_dip(100); no_rst(110); join
        sleep <= 1'b0;
        fork i_env.supply_dip(30); wait_rst(); join
        chk(c >= 36 && c <= 64, 1'b1);
        rc(FLAGS_OFFS, 32'h00000004);
        rc(STATUS_OFFS, 32'h00000003);
        $display("low voltage test done");
    endtask
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, arvalid, sleep, wdt} = 5'h00;
        {bready, rready} = 2'h0;
        {awaddr, araddr, wstrb} = 12'h00F;
        wdata = 32'h00000000;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        n = 0;
        do step(); while (core_rst !== 1'b0);
        t_por();
        t_pin();
        t_code();
        t_wdcode();
        t_wdt();
        t_lv();
        end_sim();
    end
endmodule
`default_nettype wire
